// [verilog/pgd_dev.sv]
// decoder end of the host word port: frames, set/read commands, receive buffer
// assumes the radio core feeds decoded words on pclk and host pins are async
`timescale 1ns/10ps
module pgd_dev
	import pgd_pkg::*;
#(
	parameter int unsigned DEPTH = PGD_DEPTH_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	pgd_link_if.dev link,
	input wire logic rx_valid,
	input wire logic rx_is_msg,
	input wire logic [2:0] rx_call_sign,
	input wire logic [1:0] rx_func,
	input wire logic [1:0] rx_err,
	input wire logic rx_parity_err,
	input wire logic [19:0] rx_content,
	input wire logic msg_end,
	input wire logic sync_quality_flag,
	input wire logic coverage_input_a,
	input wire logic idle_mode,
	input wire logic preamble_mode,
	input wire logic lock_mode,
	input wire logic receiving_indicator,
	input wire logic ram_busy,
	output pgd_mode_t mode_ff,
	output logic break_ff,
	output logic start_ff,
	output logic wr_strobe_ff,
	output logic [31:0] wr_data_ff
);
	localparam int unsigned AW = $clog2(DEPTH);
	typedef enum logic [1:0] {
		PGD_FR_NONE = 2'b00,
		PGD_FR_CMD = 2'b01,
		PGD_FR_READ = 2'b10,
		PGD_FR_FETCH = 2'b11
	} pgd_frame_t;
	// ==========================================================
	// pin synchronisation
	logic [4:0] pin_s; // sclk, cs, fetch, di, coverage_input_a after two flops
	pgd_sync #(.W(5)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d({link.ser_clk, link.ser_cs, link.ser_fetch, link.ser_di, coverage_input_a}),
		.q(pin_s)
	);
	logic sclk_d_ff, cs_d_ff, fetch_d_ff; // previous synced levels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_d_ff <= 1'b0;
			cs_d_ff <= 1'b0;
			fetch_d_ff <= 1'b0;
		end else begin
			sclk_d_ff <= pin_s[4];
			cs_d_ff <= pin_s[3];
			fetch_d_ff <= pin_s[2];
		end
	end
	logic sclk_rise, cs_rise, cs_fall, fetch_rise, fetch_fall;
	assign sclk_rise = pin_s[4] & ~sclk_d_ff;
	assign cs_rise = pin_s[3] & ~cs_d_ff;
	assign cs_fall = ~pin_s[3] & cs_d_ff;
	assign fetch_rise = pin_s[2] & ~fetch_d_ff;
	assign fetch_fall = ~pin_s[2] & fetch_d_ff;
	// ==========================================================
	// receive buffer state
	logic [31:0] mem [DEPTH]; // formatted words awaiting the host
	logic [AW-1:0] wr_ptr_ff, rd_ptr_ff;
	logic [AW:0] cnt_ff; // words held
	logic eom_pend_ff; // end word waiting for a free push slot
	logic push, pop;
	logic [31:0] push_word;
	// ==========================================================
	// frame state
	pgd_frame_t frame_ff;
	logic [5:0] bit_ff; // bits taken in this frame
	logic [31:0] in_ff; // host bits, first bit ends up msb
	logic [31:0] out_ff; // bits still to send, msb next
	logic sdo_ff;
	logic word_ready_ff;
	logic [7:0] cmd_byte;
	logic cmd_done;
	logic [7:0] status_byte;
	assign cmd_byte = {in_ff[6:0], pin_s[1]};
	assign cmd_done = (frame_ff == PGD_FR_CMD) && sclk_rise && (bit_ff == 6'(PGD_CMD_BITS - 1));
	// status: leading zero, coverage_input_a, idle, preamble, lock, write, receiving, busy
	assign status_byte = {1'b0,
		pin_s[0],
		idle_mode, preamble_mode, lock_mode, mode_ff == PGD_MODE_WRITE,
		receiving_indicator,
		ram_busy | wr_strobe_ff};
	assign link.serial_data_out = sdo_ff;
	assign link.word_ready = word_ready_ff;
	// ==========================================================
	// frame engine: shift in on rising link clock, move output after it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_ff <= PGD_FR_NONE;
			bit_ff <= '0;
			in_ff <= '0;
			out_ff <= '0;
			sdo_ff <= 1'b0;
		end else if (cs_rise) begin
			frame_ff <= PGD_FR_CMD;
			bit_ff <= '0;
			sdo_ff <= 1'b0; // command bits: output means nothing
		end else if (fetch_rise) begin
			frame_ff <= PGD_FR_FETCH;
			bit_ff <= '0;
			out_ff <= (cnt_ff != '0) ? mem[rd_ptr_ff] : '0;
			sdo_ff <= (cnt_ff != '0) ? mem[rd_ptr_ff][31] : 1'b0;
		end else if (cs_fall || fetch_fall) begin
			frame_ff <= PGD_FR_NONE;
		end else if (sclk_rise && frame_ff != PGD_FR_NONE) begin
			in_ff <= {in_ff[30:0], pin_s[1]};
			if (bit_ff != 6'(PGD_WORD_BITS)) begin
				bit_ff <= bit_ff + 6'd1; // count holds at a word on extra clocks; in_ff still shifts them in
			end
			if (cmd_done && cmd_byte == PGD_READ_CMD) begin
				frame_ff <= PGD_FR_READ;
				out_ff <= {status_byte, 24'h000000};
				sdo_ff <= status_byte[7];
			end else if (frame_ff == PGD_FR_READ || frame_ff == PGD_FR_FETCH) begin
				out_ff <= {out_ff[30:0], 1'b0};
				sdo_ff <= out_ff[30];
			end
		end
	end
	// ==========================================================
	// set command decode and mode keeping
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ff <= PGD_MODE_NORMAL;
			break_ff <= 1'b0;
			start_ff <= 1'b0;
		end else begin
			break_ff <= 1'b0;
			start_ff <= 1'b0;
			// header 1,0 in bits 1..2 and 0 in bit 8
			if (cmd_done && cmd_byte[7:6] == 2'b10 && !cmd_byte[0]) begin
				if (cmd_byte[PGD_SET_BREAK]) begin
					break_ff <= 1'b1;
				end else if (cmd_byte[PGD_SET_BACKUP]) begin
					mode_ff <= PGD_MODE_BACKUP;
				end else if (cmd_byte[PGD_SET_WRITE] && mode_ff != PGD_MODE_WRITE) begin
					mode_ff <= PGD_MODE_WRITE;
				end else if (cmd_byte[PGD_SET_TEST]) begin
					mode_ff <= PGD_MODE_TEST;
				end else if (cmd_byte[PGD_SET_START] && mode_ff != PGD_MODE_NORMAL) begin
					mode_ff <= PGD_MODE_NORMAL;
					start_ff <= 1'b1;
				end
			end
		end
	end
	// ==========================================================
	// write words: whole 32-bit frame in write mode while not busy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_strobe_ff <= 1'b0;
			wr_data_ff <= '0;
		end else begin
			wr_strobe_ff <= 1'b0;
			// a word that lands while busy is dropped, the host must wait
			if (cs_fall && frame_ff == PGD_FR_CMD && bit_ff == 6'(PGD_WORD_BITS)
				&& mode_ff == PGD_MODE_WRITE && !ram_busy && !wr_strobe_ff) begin
				wr_strobe_ff <= 1'b1;
				wr_data_ff <= in_ff;
			end
		end
	end
	// ==========================================================
	// word formatting for the buffer
	always_comb begin
		if (rx_valid && rx_is_msg) begin
			push_word = {PGD_HDR_MSG,
				sync_quality_flag, rx_err,
				rx_parity_err,
				rx_content};
		end else if (rx_valid) begin
			push_word = {PGD_HDR_ADDR, rx_call_sign, rx_func,
				sync_quality_flag, rx_err,
				rx_parity_err,
				rx_content[19:2], rx_func};
		end else begin
			// undefined bits 10..12 are driven zero
			push_word = {PGD_HDR_EOM, sync_quality_flag, 3'h0, 20'h00000};
		end
	end
	// a received word beats a pending end word; a full buffer drops the push
	assign push = (rx_valid || eom_pend_ff) && (cnt_ff != (AW + 1)'(DEPTH));
	assign pop = fetch_rise && (cnt_ff != '0);
	// ==========================================================
	// end word requests: message end, or break during reception
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eom_pend_ff <= 1'b0;
		end else if (msg_end || (break_ff && receiving_indicator)) begin
			eom_pend_ff <= 1'b1;
		end else if (push && !rx_valid) begin
			eom_pend_ff <= 1'b0;
		end
	end
	// ==========================================================
	// buffer pointers and storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff <= '0;
			word_ready_ff <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + AW'(1);
			end
			if (pop) begin
				rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + AW'(1);
			end
			cnt_ff <= cnt_ff + (AW + 1)'(push) - (AW + 1)'(pop);
			word_ready_ff <= (cnt_ff + (AW + 1)'(push) - (AW + 1)'(pop)) != '0;
		end
	end
	// storage has no reset: contents only matter once counted
	always_ff @(posedge pclk) begin
		if (push) begin
			mem[wr_ptr_ff] <= push_word;
		end
	end
endmodule

// [verilog/pgd_pkg.sv]
// shared constants for the pager decoder host word port, both ends
// assumes one 50 MHz clock domain per end and a serial link between them
package pgd_pkg;
	// ==========================================================
	// link framing
	localparam int unsigned PGD_CMD_BITS = 8;
	localparam int unsigned PGD_READ_BITS = 16;
	localparam int unsigned PGD_WORD_BITS = 32;
	localparam logic [7:0] PGD_READ_CMD = 8'h81;
	localparam int unsigned PGD_HALF_DEF = 16; // pclk cycles per half link clock
	localparam int unsigned PGD_DEPTH_DEF = 4; // receive buffer words
	// ==========================================================
	// word headers, bit 1 is vector bit 31
	localparam logic [2:0] PGD_HDR_ADDR = 3'h5;
	localparam logic [7:0] PGD_HDR_MSG = 8'hc0;
	localparam logic [7:0] PGD_HDR_EOM = 8'he0;
	// ==========================================================
	// set command bit positions inside the byte (bit 1 = index 7)
	localparam int unsigned PGD_SET_BREAK = 5;
	localparam int unsigned PGD_SET_BACKUP = 4;
	localparam int unsigned PGD_SET_WRITE = 3;
	localparam int unsigned PGD_SET_TEST = 2;
	localparam int unsigned PGD_SET_START = 1;
	// ==========================================================
	// host apb register offsets
	localparam logic [7:0] PGD_REG_CMD = 8'h00;
	localparam logic [7:0] PGD_REG_WDATA = 8'h04;
	localparam logic [7:0] PGD_REG_FETCH = 8'h08;
	localparam logic [7:0] PGD_REG_STAT = 8'h0c;
	localparam logic [7:0] PGD_REG_RDATA = 8'h10;
	localparam real PGD_WRITE_GAP_MS = 28.4;
	localparam real PGD_CLK_MHZ = 50.0;
	localparam int unsigned PGD_WRITE_GAP_CYC = int'(PGD_WRITE_GAP_MS * 1000.0 * PGD_CLK_MHZ);
	// ==========================================================
	// decoder operating modes
	typedef enum logic [1:0] {
		PGD_MODE_NORMAL = 2'b00,
		PGD_MODE_BACKUP = 2'b01,
		PGD_MODE_WRITE = 2'b10,
		PGD_MODE_TEST = 2'b11
	} pgd_mode_t;
endpackage

// [verilog/pgd_link_if.sv]
// serial link between host controller and decoder word port
// assumes the bench resolves nothing: all wires are one-way
`timescale 1ns/10ps
interface pgd_link_if;
	logic ser_clk; // link clock made by the host
	logic ser_cs; // command or write frame
	logic ser_fetch; // received word fetch frame
	logic ser_di; // host to device data
	logic serial_data_out; // device to host data
	logic word_ready; // device holds an unread word
	modport host (output ser_clk, output ser_cs, output ser_fetch, output ser_di,
		input serial_data_out, input word_ready);
	modport dev (input ser_clk, input ser_cs, input ser_fetch, input ser_di,
		output serial_data_out, output word_ready);
endinterface

// [verilog/pgd_sync.sv]
// two flip-flop synchroniser for a group of pin inputs
// assumes each bit is independent; no bus coherence implied
`timescale 1ns/10ps
module pgd_sync #(
	parameter int unsigned W = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_ff; // first stage, read only by q
	// ==========================================================
	// two stages against metastability
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff <= '0;
			q <= '0;
		end else begin
			meta_ff <= d;
			q <= meta_ff;
		end
	end
endmodule

// [verilog/pgd_host.sv]
// host controller end: apb registers drive command, write and fetch frames
// assumes the device samples on rising link clock and moves data after it
`timescale 1ns/10ps
module pgd_host
	import pgd_pkg::*;
#(
	parameter int unsigned HALF = PGD_HALF_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	pgd_link_if.host link
);
	typedef enum logic [1:0] {
		PGD_H_IDLE = 2'b00,
		PGD_H_LOW = 2'b01,
		PGD_H_HIGH = 2'b10,
		PGD_H_TAIL = 2'b11
	} pgd_hstate_t;
	pgd_hstate_t st_ff;
	logic [15:0] tmr_ff; // half period timer
	logic [5:0] left_ff; // bits still to clock
	logic [31:0] tx_ff, rx_ff, rdata_ff;
	logic [7:0] stat_ff; // last status byte read
	logic clk_ff, cs_ff, fetch_ff, read_ff;
	logic [1:0] pin_s; // sdo, word_ready after two flops
	logic acc, start_cmd, start_wr, start_fetch;
	pgd_sync #(.W(2)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d({link.serial_data_out, link.word_ready}),
		.q(pin_s)
	);
	assign link.ser_clk = clk_ff;
	assign link.ser_cs = cs_ff;
	assign link.ser_fetch = fetch_ff;
	assign link.ser_di = tx_ff[31];
	// ==========================================================
	// apb decode: zero wait states, writes while busy are dropped
	assign acc = psel && penable && pwrite && st_ff == PGD_H_IDLE;
	assign start_cmd = acc && paddr == PGD_REG_CMD;
	assign start_wr = acc && paddr == PGD_REG_WDATA;
	assign start_fetch = acc && paddr == PGD_REG_FETCH;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !(paddr == PGD_REG_CMD || paddr == PGD_REG_WDATA
				|| paddr == PGD_REG_FETCH || paddr == PGD_REG_STAT || paddr == PGD_REG_RDATA);
			prdata <= '0;
			if (psel && !penable && !pwrite && paddr == PGD_REG_STAT) begin
				prdata <= {16'h0000, stat_ff, 6'h00, pin_s[0], st_ff != PGD_H_IDLE};
			end else if (psel && !penable && !pwrite && paddr == PGD_REG_RDATA) begin
				prdata <= rdata_ff;
			end
		end
	end
	// ==========================================================
	// frame sequencer: low half, then high half with sample, per bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= PGD_H_IDLE;
			tmr_ff <= '0;
			left_ff <= '0;
			tx_ff <= '0;
			rx_ff <= '0;
			clk_ff <= 1'b0;
			cs_ff <= 1'b0;
			fetch_ff <= 1'b0;
			read_ff <= 1'b0;
		end else begin
			unique case (st_ff)
				PGD_H_IDLE: begin
					tmr_ff <= 16'(HALF - 1);
					if (start_cmd) begin
						// software keeps to one mode bit per set command
						read_ff <= pwdata[7:0] == PGD_READ_CMD;
						left_ff <= (pwdata[7:0] == PGD_READ_CMD) ? 6'(PGD_READ_BITS) : 6'(PGD_CMD_BITS);
						tx_ff <= {pwdata[7:0], 24'h000000};
						cs_ff <= 1'b1;
						st_ff <= PGD_H_LOW;
					end else if (start_wr) begin
						// pacing by busy or a 28.4 ms gap is left to software
						read_ff <= 1'b0;
						left_ff <= 6'(PGD_WORD_BITS);
						tx_ff <= pwdata;
						cs_ff <= 1'b1;
						st_ff <= PGD_H_LOW;
					end else if (start_fetch) begin
						read_ff <= 1'b0;
						left_ff <= 6'(PGD_WORD_BITS);
						tx_ff <= '0;
						fetch_ff <= 1'b1;
						st_ff <= PGD_H_LOW;
					end
				end
				PGD_H_LOW: begin
					tmr_ff <= tmr_ff - 16'd1;
					if (tmr_ff == '0) begin
						clk_ff <= 1'b1;
						rx_ff <= {rx_ff[30:0], pin_s[1]};
						tmr_ff <= 16'(HALF - 1);
						st_ff <= PGD_H_HIGH;
					end
				end
				PGD_H_HIGH: begin
					tmr_ff <= tmr_ff - 16'd1;
					if (tmr_ff == '0) begin
						clk_ff <= 1'b0;
						tx_ff <= {tx_ff[30:0], 1'b0};
						left_ff <= left_ff - 6'd1;
						tmr_ff <= 16'(HALF - 1);
						st_ff <= (left_ff == 6'd1) ? PGD_H_TAIL : PGD_H_LOW;
					end
				end
				PGD_H_TAIL: begin
					tmr_ff <= tmr_ff - 16'd1;
					if (tmr_ff == '0) begin
						cs_ff <= 1'b0;
						fetch_ff <= 1'b0;
						st_ff <= PGD_H_IDLE;
					end
				end
			endcase
		end
	end
	// ==========================================================
	// results: status byte from the last eight bits of a read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_ff <= '0;
			rdata_ff <= '0;
		end else if (st_ff == PGD_H_TAIL && tmr_ff == '0) begin
			if (read_ff) begin
				stat_ff <= rx_ff[7:0];
			end else if (fetch_ff) begin
				// bits 10..12 of an end word are passed on uninterpreted
				rdata_ff <= rx_ff;
			end
		end
	end
endmodule

// [verification/pgd_link_sva.sv]
// checker for the serial link between the host controller and the decoder
// assumes one pclk domain; wired beside the link interface by tb_top
`timescale 1ns/10ps
module pgd_link_sva
	import pgd_pkg::*;
#(
	parameter int unsigned HALF = PGD_HALF_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ser_clk,
	input wire logic ser_cs,
	input wire logic ser_fetch,
	input wire logic ser_di,
	input wire pgd_mode_t mode_ff,
	input wire logic start_ff,
	input wire logic break_ff
);
	// ==========================================================
	// helper counters
	logic clk_q_ff; // link clock one pclk late
	logic [5:0] hi_cnt_ff; // cycles the link clock has stood high
	logic [5:0] bits_ff; // rising link edges in this frame
	logic [15:0] sh_ff; // host data taken at each rising edge
	// edge counting; frames never exceed 32 bits so 6 bits suffice
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_q_ff <= 1'b0;
			hi_cnt_ff <= 6'h0;
			bits_ff <= 6'h0;
			sh_ff <= 16'h0;
		end else begin
			clk_q_ff <= ser_clk;
			hi_cnt_ff <= ser_clk ? hi_cnt_ff + 6'h1 : 6'h0;
			if (!ser_cs && !ser_fetch) begin
				bits_ff <= 6'h0;
			end else if (ser_clk && !clk_q_ff) begin
				bits_ff <= bits_ff + 6'h1;
			end
			if (ser_clk && !clk_q_ff) begin
				sh_ff <= {sh_ff[14:0], ser_di};
			end
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================================
	// assertions
	AST_NO_OVERLAP: assert property (!(ser_cs && ser_fetch))
		else $error("command and fetch frames overlap");
	AST_CLK_IDLE: assert property (!ser_cs && !ser_fetch |-> !ser_clk)
		else $error("link clock runs outside a frame");
	AST_CLK_HIGH: assert property ($fell(ser_clk) |-> hi_cnt_ff == 6'(HALF))
		else $error("link clock high phase has wrong length");
	// lead-in of six cycles matches the HALF the bench sets
	AST_LEAD_LOW: assert property ($rose(ser_cs) || $rose(ser_fetch) |-> !ser_clk [*6])
		else $error("link clock rose too early in frame");
	AST_CMD_LEN: assert property ($fell(ser_cs) |-> bits_ff == 6'd8 || bits_ff == 6'd16 || bits_ff == 6'd32)
		else $error("command frame has wrong bit count");
	AST_FETCH_LEN: assert property ($fell(ser_fetch) |-> bits_ff == 6'd32)
		else $error("fetch frame is not 32 bits");
	AST_READ_CODE: assert property ($fell(ser_cs) && bits_ff == 6'd16 |-> sh_ff[15:8] == PGD_READ_CMD)
		else $error("read frame carries wrong command");
	AST_SET_FORM: assert property ($fell(ser_cs) && bits_ff == 6'd8 |-> sh_ff[7:6] == 2'b10 && !sh_ff[0])
		else $error("set command framing bits wrong");
	AST_START_GATE: assert property (start_ff |-> $past(mode_ff) != PGD_MODE_NORMAL)
		else $error("start honoured in normal mode");
	AST_PULSES: assert property (start_ff || break_ff |=> !start_ff && !break_ff)
		else $error("mode pulse longer than one cycle");
	// ==========================================================
	// scenario coverage
	COV_FETCH: cover property ($fell(ser_fetch));
	COV_READ: cover property ($fell(ser_cs) && bits_ff == 6'd16);
	COV_START: cover property (start_ff);
	COV_BREAK: cover property (break_ff);
endmodule

// [verification/tb_top.sv]
// top testbench: apb master on the host end, radio side stimulus on the device end
// assumes HALF=6 on the host and DEPTH default on the device
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
	$display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module tb_top
	import pgd_pkg::*;
;
	localparam int unsigned HALF = 6;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic rx_valid, rx_is_msg, rx_parity_err, msg_end, sync_quality_flag, coverage_input_a;
	logic [2:0] rx_call_sign;
	logic [1:0] rx_func, rx_err;
	logic [19:0] rx_content;
	logic idle_mode, preamble_mode, lock_mode, receiving_indicator, ram_busy;
	pgd_mode_t mode_ff;
	logic start_ff, break_ff, wr_strobe_ff;
	logic [31:0] wr_data_ff, wr_last_ff;
	int mismatches, tests_run, cyc, start_seen_ff, break_seen_ff, wr_seen_ff;
	pgd_link_if lnk();
	pgd_host #(.HALF(HALF)) u_pgd_host(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(lnk));
	pgd_dev u_pgd_dev(.pclk(pclk), .presetn(presetn), .link(lnk), .rx_valid(rx_valid), .rx_is_msg(rx_is_msg),
		.rx_call_sign(rx_call_sign), .rx_func(rx_func), .rx_err(rx_err), .rx_parity_err(rx_parity_err),
		.rx_content(rx_content), .msg_end(msg_end), .sync_quality_flag(sync_quality_flag),
		.coverage_input_a(coverage_input_a), .idle_mode(idle_mode), .preamble_mode(preamble_mode),
		.lock_mode(lock_mode), .receiving_indicator(receiving_indicator), .ram_busy(ram_busy),
		.mode_ff(mode_ff), .break_ff(break_ff), .start_ff(start_ff), .wr_strobe_ff(wr_strobe_ff),
		.wr_data_ff(wr_data_ff));
	pgd_link_sva #(.HALF(HALF)) u_pgd_link_sva(.pclk(pclk), .presetn(presetn), .ser_clk(lnk.ser_clk),
		.ser_cs(lnk.ser_cs), .ser_fetch(lnk.ser_fetch), .ser_di(lnk.ser_di), .mode_ff(mode_ff),
		.start_ff(start_ff), .break_ff(break_ff));
	// ==========================================================
	// clock, pulse monitor and hang guard
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	// pulses are one cycle, so they are counted at every edge
	always @(posedge pclk) begin
		cyc++;
		if (start_ff === 1'b1) start_seen_ff++;
		if (break_ff === 1'b1) break_seen_ff++;
		if (wr_strobe_ff === 1'b1) begin
			wr_seen_ff++;
			wr_last_ff = wr_data_ff;
		end
		if (cyc > 60000) begin
			mismatches++;
			stop_test;
		end
	end
	task automatic stop_test;
		$display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// ==========================================================
	// bus and link helpers
	// one apb transfer; answer taken at the rising edge that samples pready high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// request stands until pready is seen high at a rising edge
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_idle;
		logic [31:0] q;
		do apb(1'b0, PGD_REG_STAT, 32'h0, q); while (q[0] !== 1'b0);
	endtask
	task automatic send(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
		wait_idle;
	endtask
	task automatic fetch(output logic [31:0] w);
		send(PGD_REG_FETCH, 32'h0);
		apb(1'b0, PGD_REG_RDATA, 32'h0, w);
	endtask
	task automatic rx_word(input logic m, input logic p, input logic [1:0] e, input logic [19:0] c, input logic s);
		@(posedge pclk);
		rx_valid <= 1'b1;
		rx_is_msg <= m;
		rx_parity_err <= p;
		rx_err <= e;
		rx_content <= c;
		sync_quality_flag <= s;
		@(posedge pclk);
		rx_valid <= 1'b0;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_reset;
		logic [31:0] q;
		`CHK(mode_ff, PGD_MODE_NORMAL)
		apb(1'b0, PGD_REG_STAT, 32'h0, q);
		`CHK(q, 32'h0)
		apb(1'b0, 8'h20, 32'h0, q); // unmapped place
		`CHK(err_q, 1'b1)
		fetch(q);
		`CHK(q, 32'h0)
	endtask
	task automatic t_words;
		logic [31:0] q;
		rx_word(1'b0, 1'b0, 2'b01, 20'h96a5e, 1'b1);
		// word ready crosses two synchroniser flops before the host sees it
		repeat (2) @(posedge pclk);
		apb(1'b0, PGD_REG_STAT, 32'h0, q);
		`CHK(q[1], 1'b1)
		fetch(q);
		`CHK(q, {3'b101, 3'h5, 2'b10, 1'b1, 2'b01, 1'b0, 18'h25a97, 2'b10})
		// every correction code, parity both ways
		for (int i = 0; i < 4; i++) begin
			rx_word(1'b1, i[0], i[1:0], 20'h5c3a9 ^ 20'(i), 1'b0);
			fetch(q);
			`CHK(q, {8'hc0, 1'b0, i[1:0], i[0], 20'h5c3a9 ^ 20'(i)})
		end
		@(posedge pclk);
		sync_quality_flag <= 1'b1;
		msg_end <= 1'b1;
		@(posedge pclk);
		msg_end <= 1'b0;
		fetch(q);
		`CHK(q & 32'hff8fffff, {8'he0, 1'b1, 3'b000, 20'h0})
		// buffer drained: no word ready, host idle
		apb(1'b0, PGD_REG_STAT, 32'h0, q);
		`CHK(q[1:0], 2'b00)
	endtask
	task automatic t_modes;
		logic [7:0] cmd [9] = '{8'h82, 8'h90, 8'h82, 8'h84, 8'h82, 8'h88, 8'h82, 8'h88, 8'h88};
		pgd_mode_t exp [9] = '{PGD_MODE_NORMAL, PGD_MODE_BACKUP, PGD_MODE_NORMAL, PGD_MODE_TEST,
			PGD_MODE_NORMAL, PGD_MODE_WRITE, PGD_MODE_NORMAL, PGD_MODE_WRITE, PGD_MODE_WRITE};
		for (int i = 0; i < 9; i++) begin
			send(PGD_REG_CMD, {24'h0, cmd[i]});
			`CHK(mode_ff, exp[i])
		end
		`CHK(start_seen_ff, 3)
	endtask
	task automatic t_status;
		logic [5:0] pat [2] = '{6'b101011, 6'b010100};
		logic [31:0] q;
		for (int i = 0; i < 2; i++) begin
			@(posedge pclk);
			{coverage_input_a, idle_mode, preamble_mode, lock_mode, receiving_indicator, ram_busy} <= pat[i];
			send(PGD_REG_CMD, {24'h0, PGD_READ_CMD});
			apb(1'b0, PGD_REG_STAT, 32'h0, q);
			`CHK(q[15:8], {1'b0, pat[i][5:2], 1'b1, pat[i][1:0]})
		end
	endtask
	task automatic t_write;
		@(posedge pclk);
		ram_busy <= 1'b0;
		send(PGD_REG_WDATA, 32'hc3a50f96);
		// the strobe trails the frame end by the device's pin synchroniser
		repeat (4) @(posedge pclk);
		`CHK(wr_seen_ff, 1)
		`CHK(wr_last_ff, 32'hc3a50f96)
		@(posedge pclk);
		ram_busy <= 1'b1;
		send(PGD_REG_WDATA, 32'h12345678);
		repeat (4) @(posedge pclk);
		`CHK(wr_seen_ff, 1)
	endtask
	task automatic t_break;
		logic [31:0] q;
		@(posedge pclk);
		ram_busy <= 1'b0;
		receiving_indicator <= 1'b1;
		send(PGD_REG_CMD, 32'ha0);
		`CHK(break_seen_ff, 1)
		@(posedge pclk);
		receiving_indicator <= 1'b0;
		fetch(q);
		`CHK(q & 32'hff8fffff, {8'he0, 1'b1, 3'b000, 20'h0})
	endtask
	// ==========================================================
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, rx_valid, rx_is_msg, rx_parity_err, msg_end} = '0;
		{sync_quality_flag, coverage_input_a, idle_mode, preamble_mode, lock_mode} = '0;
		{receiving_indicator, ram_busy} = '0;
		paddr = 8'h0;
		pwdata = 32'h0;
		rx_call_sign = 3'h5;
		rx_func = 2'b10;
		rx_err = 2'b00;
		rx_content = 20'h0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_words;
		t_modes;
		t_status;
		t_write;
		t_break;
		stop_test;
	end
endmodule
